//--- common/pmi_pkg.sv
// constants and types shared by the program memory and port interface
package pmi_pkg;

  // instruction cycle slots, one per processor clock period
  typedef enum logic [2:0] {
    PMI_A1,
    PMI_A2,
    PMI_A3,
    PMI_M1,
    PMI_M2,
    PMI_X1,
    PMI_X2,
    PMI_X3
  } pmi_slot_type;

  // widths
  localparam int unsigned PMI_NIB_W   = 4;
  localparam int unsigned PMI_BYTE_W  = 8;
  localparam int unsigned PMI_SYNC_W  = 19;

  // port-group instruction: upper opcode nibble, then lower operand nibble codes
  localparam logic [3:0] PMI_OPR_IO    = 4'he;
  localparam logic [3:0] PMI_OPA_WRITE = 4'h2;
  localparam logic [3:0] PMI_OPA_PWR   = 4'h3;
  localparam logic [3:0] PMI_OPA_READ  = 4'ha;
  // port select command: upper nibble, odd lower nibble
  localparam logic [3:0] PMI_OPR_SEL   = 4'h2;
  localparam int unsigned PMI_SEL_BIT  = 0;

  // chip select code forced during a program write
  localparam logic [3:0] PMI_CS_RAM    = 4'hf;

  // reset values
  localparam logic [7:0] PMI_ADDR_RST  = 8'h00;
  localparam logic [3:0] PMI_CS_RST    = 4'h0;
  localparam logic [7:0] PMI_SEL_RST   = 8'h00;
  localparam logic [7:0] PMI_INSTR_RST = 8'h00;
  localparam logic [3:0] PMI_NIB_RST   = 4'h0;
  localparam logic       PMI_HALF_RST  = 1'b1;

  // synchronised pin bundle layout
  localparam int unsigned PMI_B_PHI2  = 0;
  localparam int unsigned PMI_B_SYNC  = 1;
  localparam int unsigned PMI_B_CMD   = 2;
  localparam int unsigned PMI_B_NIB   = 3;
  localparam int unsigned PMI_B_PORT  = 7;
  localparam int unsigned PMI_B_INSTR = 11;

endpackage

//--- common/pmi_pin_if.sv
// synchronised processor and memory pins, passed from synchroniser to core
`timescale 1ns/1ps
`default_nettype none
interface pmi_pin_if;
  import pmi_pkg::*;
  logic       phi2;
  logic       sync;
  logic       cmd;
  logic [3:0] nib;
  logic [3:0] port;
  logic [7:0] instr;

  modport src (output phi2, output sync, output cmd, output nib, output port, output instr);
  modport dst (input phi2, input sync, input cmd, input nib, input port, input instr);
endinterface
`default_nettype wire

//--- hdl/pmi_sync.sv
// two-stage synchroniser for every pin that enters the core
`timescale 1ns/1ps
`default_nettype none
module pmi_sync (
  // clock and reset
  input  wire logic                         sys_clk_in,
  input  wire logic                         rst_in,
  // raw pins
  input  wire logic [pmi_pkg::PMI_SYNC_W-1:0] raw_in,
  // synchronised bundle
  pmi_pin_if.src                            pins
);
  import pmi_pkg::*;

  typedef struct packed {
    logic [PMI_SYNC_W-1:0] meta;
    logic [PMI_SYNC_W-1:0] stab;
  } pmi_sync_state_type;

  pmi_sync_state_type q;
  pmi_sync_state_type d;

  // first stage is read only by the second
  always_comb begin
    d      = q;
    d.meta = raw_in;
    d.stab = q.meta;
  end

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign pins.phi2  = q.stab[PMI_B_PHI2];
  assign pins.sync  = q.stab[PMI_B_SYNC];
  assign pins.cmd   = q.stab[PMI_B_CMD];
  assign pins.nib   = q.stab[PMI_B_NIB +: PMI_NIB_W];
  assign pins.port  = q.stab[PMI_B_PORT +: PMI_NIB_W];
  assign pins.instr = q.stab[PMI_B_INSTR +: PMI_BYTE_W];
endmodule
`default_nettype wire

//--- hdl/pmi_top.sv
// address latch and transfer logic between a nibble-bus processor and memory/ports
`timescale 1ns/1ps
`default_nettype none
module pmi_top (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  // processor side
  input  wire logic        phi2_in,
  input  wire logic        sync_in,
  input  wire logic        memory_command_line_in,
  input  wire logic [3:0]  shared_nibble_bus_in,
  output logic      [3:0]  shared_nibble_bus_out,
  output logic             shared_nibble_bus_oe_n_out,
  // program memory side
  input  wire logic [7:0]  instr_byte_in,
  output logic      [7:0]  low_address_lines_out,
  output logic      [3:0]  chip_select_lines_out,
  output logic             write_prog_n_out,
  output logic             half_select_out,
  // port side
  input  wire logic [3:0]  port_bus_in,
  output logic      [3:0]  port_bus_out,
  output logic             port_bus_oe_n_out,
  output logic             in_strobe_n_out,
  output logic             out_strobe_n_out
);
  import pmi_pkg::*;

  typedef struct packed {
    pmi_slot_type slot;
    logic         phi2_prev;
    logic         sync_seen;
    logic         fetch_en;
    logic         io_q;
    logic         sel_q;
    logic [7:0]   instr;
    logic [7:0]   sel_reg;
    logic [7:0]   addr;
    logic [3:0]   cs;
    logic         half;
    logic         wr_n;
    logic         in_n;
    logic         out_n;
    logic [3:0]   nib;
    logic         nib_oe_n;
    logic [3:0]   port;
    logic         port_oe_n;
  } pmi_state_type;

  pmi_pin_if pins ();

  pmi_state_type q;
  pmi_state_type d;

  logic phi2_fall;
  logic is_read;
  logic is_write;
  logic is_pwr;

  // every pin is synchronised before the core looks at it
  pmi_sync u_sync (
    .sys_clk_in (sys_clk_in),
    .rst_in     (rst_in),
    .raw_in     ({instr_byte_in, port_bus_in, shared_nibble_bus_in,
                  memory_command_line_in, sync_in, phi2_in}),
    .pins       (pins)
  );

  always_comb begin
    d         = q;
    phi2_fall = q.phi2_prev & ~pins.phi2;
    is_read   = q.io_q & (q.instr[3:0] == PMI_OPA_READ);
    is_write  = q.io_q & (q.instr[3:0] == PMI_OPA_WRITE);
    is_pwr    = q.io_q & (q.instr[3:0] == PMI_OPA_PWR);

    d.phi2_prev = pins.phi2;
    // sync seen while phi2 is high is latched; sync still present at the phi2 fall also counts
    if (pins.sync & pins.phi2) begin
      d.sync_seen = 1'b1;
    end

    // bus data is taken as the second phase closes each slot except PMI_X1
    if (phi2_fall) begin
      case (q.slot)
        PMI_A1: begin
          d.addr[3:0] = pins.nib;
        end
        PMI_A2: begin
          d.addr[7:4] = pins.nib;
        end
        PMI_A3: begin
          d.cs       = pins.nib;
          d.fetch_en = pins.cmd;
          d.io_q     = 1'b0;
          d.sel_q    = 1'b0;
        end
        PMI_M1: begin
          d.instr = instr_bytes_q(pins.instr, q.fetch_en, q.instr);
        end
        PMI_M2: begin
          // port group is only trusted when the processor flags it
          d.io_q  = q.fetch_en & pins.cmd & (q.instr[7:4] == PMI_OPR_IO);
          d.sel_q = q.fetch_en & (q.instr[7:4] == PMI_OPR_SEL)
                    & q.instr[PMI_SEL_BIT];
          d.addr  = q.sel_reg;
          d.cs    = q.sel_reg[7:4];
          if (q.fetch_en & pins.cmd & (q.instr[7:4] == PMI_OPR_IO)
              & (q.instr[3:0] == PMI_OPA_PWR)) begin
            d.cs = PMI_CS_RAM;
          end
        end
        PMI_X2: begin
          if (q.sel_q & pins.cmd) begin
            d.sel_reg[7:4] = pins.nib;
          end
        end
        PMI_X3: begin
          if (q.sel_q) begin
            d.sel_reg[3:0] = pins.nib;
          end
          if (is_pwr) begin
            d.half = ~q.half;
          end
        end
        default: begin
          d.sync_seen = q.sync_seen;
        end
      endcase
      // sync marks the last slot, so the next slot is the first address slot
      if (q.sync_seen | pins.sync) begin
        d.slot = PMI_A1;
      end else begin
        d.slot = pmi_slot_type'(q.slot + 3'h1);
      end
      d.sync_seen = 1'b0;
    end

    // processor bus: instruction nibbles, or port read data
    d.nib_oe_n = 1'b1;
    d.nib      = q.nib;
    case (q.slot)
      PMI_M1: begin
        if (q.fetch_en) begin
          d.nib      = pins.instr[7:4];
          d.nib_oe_n = 1'b0;
        end
      end
      PMI_M2: begin
        if (q.fetch_en) begin
          d.nib      = pins.instr[3:0];
          d.nib_oe_n = 1'b0;
        end
      end
      PMI_X2: begin
        if (is_read) begin
          d.nib      = pins.port;
          d.nib_oe_n = 1'b0;
        end
      end
      default: begin
        d.nib_oe_n = 1'b1;
      end
    endcase

    // strobes live in execute slot two only
    d.in_n  = ~((q.slot == PMI_X2) & is_read);
    d.out_n = ~((q.slot == PMI_X2) & is_write);
    d.wr_n  = ~((q.slot == PMI_X2) & is_pwr);

    // port bus: driven through both late execute slots so data outlasts the strobe
    if ((q.slot == PMI_X2) & (is_write | is_pwr)) begin
      d.port      = pins.nib;
      d.port_oe_n = 1'b0;
    end else if ((q.slot == PMI_X3) & (is_write | is_pwr)) begin
      d.port_oe_n = 1'b0;
    end else begin
      d.port_oe_n = 1'b1;
    end
  end

  // instruction byte is only kept when this cycle is a fetch
  function automatic logic [7:0] instr_bytes_q(input logic [7:0] byte_in,
                                               input logic       en,
                                               input logic [7:0] hold);
    instr_bytes_q = en ? byte_in : hold;
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      q.slot      <= PMI_A1;
      q.phi2_prev <= 1'b0;
      q.sync_seen <= 1'b0;
      q.fetch_en  <= 1'b0;
      q.io_q      <= 1'b0;
      q.sel_q     <= 1'b0;
      q.instr     <= PMI_INSTR_RST;
      q.sel_reg   <= PMI_SEL_RST;
      q.addr      <= PMI_ADDR_RST;
      q.cs        <= PMI_CS_RST;
      q.half      <= PMI_HALF_RST;
      q.wr_n      <= 1'b1;
      q.in_n      <= 1'b1;
      q.out_n     <= 1'b1;
      q.nib       <= PMI_NIB_RST;
      q.nib_oe_n  <= 1'b1;
      q.port      <= PMI_NIB_RST;
      q.port_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // address and page hold between loads; select register reused for RAM writes
  assign low_address_lines_out      = q.addr;
  assign chip_select_lines_out      = q.cs;
  assign half_select_out            = q.half;
  assign write_prog_n_out           = q.wr_n;
  assign in_strobe_n_out            = q.in_n;
  assign out_strobe_n_out           = q.out_n;
  assign shared_nibble_bus_out      = q.nib;
  assign shared_nibble_bus_oe_n_out = q.nib_oe_n;
  assign port_bus_out               = q.port;
  assign port_bus_oe_n_out          = q.port_oe_n;
endmodule
`default_nettype wire

//--- tb/pmi_cpu_model.sv
// processor-side model: one instruction cycle of eight slots per request
`timescale 1ns/1ps
`default_nettype none
module pmi_cpu_model (
  // clock and request
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [31:0] nibs_in,
  input  wire logic [7:0]  cmds_in,
  input  wire logic [7:0]  drv_in,
  // processor pins and slot view
  output logic             phi2_out,
  output logic             sync_out,
  output logic             cmd_out,
  output logic             drive_out,
  output logic             mid_out,
  output logic             busy_out,
  output logic [3:0]       nib_out,
  output logic [2:0]       slot_out
);
  logic [3:0] cnt_q = 4'h0;
  logic [3:0] last_q = 4'h0;
  initial busy_out = 1'b0;
  initial slot_out = 3'h0;
  always @(posedge clk_in) begin
    if (drive_out) last_q <= nib_out;
    if (!busy_out) begin
      busy_out <= go_in;
      cnt_q <= 4'h0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hf) slot_out <= slot_out + 3'h1;
      if (cnt_q == 4'hf && slot_out == 3'h7) busy_out <= 1'b0;
    end
  end
  // values held the whole slot, four clocks past the phi2 fall
  assign drive_out = busy_out && drv_in[slot_out];
  // released bus never repeats the last value
  assign nib_out = drive_out ? nibs_in[slot_out*4 +: 4] : ~last_q;
  assign phi2_out = busy_out && cnt_q >= 4'h4 && cnt_q <= 4'hb;
  assign sync_out = busy_out && slot_out == 3'h7;
  assign cmd_out = busy_out && cmds_in[slot_out];
  assign mid_out = busy_out && cnt_q == 4'he;
endmodule
`default_nettype wire

//--- tb/pmi_top_assertions.sv
// timing checks on the interface ports
`timescale 1ns/1ps
`default_nettype none
module pmi_top_assertions (
  input wire logic       sys_clk_in,
  input wire logic       rst_in,
  input wire logic [3:0] shared_nibble_bus_in,
  input wire logic [3:0] shared_nibble_bus_out,
  input wire logic       shared_nibble_bus_oe_n_out,
  input wire logic [7:0] instr_byte_in,
  input wire logic [3:0] chip_select_lines_out,
  input wire logic       write_prog_n_out,
  input wire logic       half_select_out,
  input wire logic [3:0] port_bus_in,
  input wire logic [3:0] port_bus_out,
  input wire logic       port_bus_oe_n_out,
  input wire logic       in_strobe_n_out,
  input wire logic       out_strobe_n_out
);
  import pmi_pkg::*;
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (rst_in);
  sequence s_in_hold; !in_strobe_n_out [*6]; endsequence
  sequence s_out_hold; !out_strobe_n_out [*6]; endsequence
  property p_rst;
    disable iff (1'b0) rst_in |=> write_prog_n_out && in_strobe_n_out && out_strobe_n_out
      && shared_nibble_bus_oe_n_out && port_bus_oe_n_out && half_select_out;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_wp_cs; !write_prog_n_out |-> chip_select_lines_out == PMI_CS_RAM; endproperty
  a_wp_cs: assert property (p_wp_cs) else $error("chip select not forced");
  property p_wp_drv; $fell(write_prog_n_out) |-> ##[0:3] !port_bus_oe_n_out; endproperty
  a_wp_drv: assert property (p_wp_drv) else $error("port bus idle in write");
  property p_half;
    $changed(half_select_out) |-> chip_select_lines_out == PMI_CS_RAM && write_prog_n_out;
  endproperty
  a_half: assert property (p_half) else $error("half select moved wrongly");
  property p_in;
    s_in_hold |-> !shared_nibble_bus_oe_n_out && shared_nibble_bus_out == $past(port_bus_in, 3);
  endproperty
  a_in: assert property (p_in) else $error("port data not passed to bus");
  property p_out;
    s_out_hold |-> !port_bus_oe_n_out && port_bus_out == $past(shared_nibble_bus_in, 3);
  endproperty
  a_out: assert property (p_out) else $error("bus data not passed to port");
  property p_excl; !write_prog_n_out |-> in_strobe_n_out && out_strobe_n_out; endproperty
  a_excl: assert property (p_excl) else $error("strobe during program write");
  property p_fetch;
    $fell(shared_nibble_bus_oe_n_out) && in_strobe_n_out
      |-> ##4 shared_nibble_bus_out == instr_byte_in[7:4];
  endproperty
  a_fetch: assert property (p_fetch) else $error("upper instruction nibble wrong");
endmodule
bind pmi_top pmi_top_assertions u_pmi_top_assertions (.sys_clk_in, .rst_in,
  .shared_nibble_bus_in, .shared_nibble_bus_out, .shared_nibble_bus_oe_n_out, .instr_byte_in,
  .chip_select_lines_out, .write_prog_n_out, .half_select_out, .port_bus_in, .port_bus_out,
  .port_bus_oe_n_out, .in_strobe_n_out, .out_strobe_n_out);
`default_nettype wire

//--- tb/testbench.sv
// self-checking bench: instruction cycles through the processor model
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import pmi_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        go = 1'b0;
  logic [31:0] nibs = 32'h0;
  logic [7:0]  cmds = 8'h0, drv = 8'h0, instr = 8'h0, sel = PMI_SEL_RST, addr;
  logic [3:0]  tb_port = 4'h0, cpu_nib, dev_nib, port_out, cs, nib_pin, port_pin;
  logic        phi2, sync, cmd, cpu_drv, mid, busy, nib_oe_n, port_oe_n, wp_n, half, in_n, out_n;
  logic [2:0]  slot;
  int          n_mismatch = 0, n_tests = 0, cycles = 0;
  assign nib_pin = nib_oe_n ? cpu_nib : dev_nib;
  assign port_pin = port_oe_n ? tb_port : port_out;
  pmi_top u_pmi_top (.sys_clk_in(clk), .rst_in(rst), .phi2_in(phi2), .sync_in(sync),
    .memory_command_line_in(cmd), .shared_nibble_bus_in(nib_pin),
    .shared_nibble_bus_out(dev_nib), .shared_nibble_bus_oe_n_out(nib_oe_n),
    .instr_byte_in(instr), .low_address_lines_out(addr), .chip_select_lines_out(cs),
    .write_prog_n_out(wp_n), .half_select_out(half), .port_bus_in(port_pin),
    .port_bus_out(port_out), .port_bus_oe_n_out(port_oe_n), .in_strobe_n_out(in_n),
    .out_strobe_n_out(out_n));
  pmi_cpu_model u_pmi_cpu_model (.clk_in(clk), .go_in(go), .nibs_in(nibs), .cmds_in(cmds),
    .drv_in(drv), .phi2_out(phi2), .sync_out(sync), .cmd_out(cmd), .drive_out(cpu_drv),
    .mid_out(mid), .busy_out(busy), .nib_out(cpu_nib), .slot_out(slot));
  initial forever #2.5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      n_mismatch++;
      report_and_stop;
    end
  end
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // gap lets end-of-cycle updates land before the next request
  task automatic idle;
    wait (!busy);
    repeat (6) @(posedge clk);
    #1;
  endtask
  task automatic run(input logic [7:0] op, input logic [31:0] nb, input logic [7:0] cm,
                     input logic [7:0] dr);
    idle;
    instr = op;
    nibs = nb;
    cmds = cm;
    drv = dr;
    go = 1'b1;
    @(posedge clk);
    #1 go = 1'b0;
  endtask
  task automatic at(input pmi_slot_type s);
    do begin
      @(posedge clk);
      #1;
    end while (!(mid && slot === s));
  endtask
  task automatic t_fetch(input logic [7:0] cm);
    run(8'hc6, 32'h000005a3, cm, 8'ha7);
    at(PMI_M1);
    chk("addr", 8'ha3, addr);
    chk("page", 8'h05, {4'h0, cs});
    chk("nib hi", cm[2] ? 8'h0c : 8'h1a, {3'h0, nib_oe_n, nib_pin});
    at(PMI_M2);
    if (cm[2]) chk("nib lo", 8'h06, {3'h0, nib_oe_n, nib_pin});
    at(PMI_X1);
    chk("sel addr", sel, addr);
    chk("sel cs", {4'h0, sel[7:4]}, {4'h0, cs});
  endtask
  task automatic t_port(input logic [7:0] op, input logic [7:0] cm, input logic [7:0] dr);
    run(op, 32'h090005a3, cm, dr);
    at(PMI_X2);
    chk("out strobe", {7'h0, !(op == 8'he2 && cm[4])}, {7'h0, out_n});
    chk("in strobe", {7'h0, !(op == 8'hea)}, {7'h0, in_n});
    if (op == 8'hea) chk("read", 8'h0b, {3'h0, nib_oe_n, nib_pin});
    if (op != 8'hea && cm[4]) chk("port", 8'h09, {3'h0, port_oe_n, port_pin});
    at(PMI_X3);
    if (op != 8'hea && cm[4]) chk("port x3", 8'h00, {7'h0, port_oe_n});
  endtask
  task automatic t_pwrite;
    for (int k = 0; k < 2; k++) begin
      run(8'he3, 32'h0d0005a3, 8'h14, 8'he7);
      at(PMI_X1);
      chk("ram cs", {4'h0, PMI_CS_RAM}, {4'h0, cs});
      chk("ram addr", sel, addr);
      at(PMI_X2);
      chk("write", 8'h00, {7'h0, wp_n});
      chk("ram strobe", 8'h01, {7'h0, (cs == PMI_CS_RAM) && !wp_n});
      chk("segment", 8'h0d, {3'h0, port_oe_n, port_pin});
      idle;
      chk("half", {7'h0, k[0]}, {7'h0, half});
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    #1 rst = 1'b0;
    tb_port = 4'hb;
    idle;
    chk("half rst", 8'h01, {7'h0, half});
    t_fetch(8'h04);
    t_fetch(8'h00);
    run(8'h21, 32'he70005a3, 8'h44, 8'he7);
    sel = 8'h7e;
    t_fetch(8'h04);
    t_port(8'he2, 8'h14, 8'he7);
    t_port(8'he2, 8'h04, 8'he7);
    t_port(8'hea, 8'h14, 8'ha7);
    t_pwrite;
    report_and_stop;
  end
endmodule
`default_nettype wire
